/* File: inc/link_resolution_status_params.svh */
`ifndef LINK_RESOLUTION_STATUS_PARAMS_SVH
`define LINK_RESOLUTION_STATUS_PARAMS_SVH

// register addresses on the management port
`define ADDR_LINK_STATUS 5'h11
`define ADDR_EVENT_ENABLE 5'h12
`define ADDR_EVENT_STATUS 5'h13
`define ADDR_GEN_CONFIG 5'h14

// status word field positions
`define POS_SPEED_HI 15
`define POS_SPEED_LO 14
`define POS_DUPLEX 13
`define POS_PAGE 12
`define POS_SETTLED 11
`define POS_LINK 10
`define POS_XOVER_CD 9
`define POS_XOVER_AB 8
`define POS_GIG_MASKED 7
`define POS_SLEEP 6
`define POS_POL_HI 5
`define POS_POL_LO 2
`define POS_POL10 1
`define POS_JABBER 0

// general configuration field
`define POS_IRQ_POLARITY 13

// reset values
`define RST_ENABLES 16'h0000
`define RST_GEN_CONFIG 16'h0000

`endif

/* File: inc/link_resolution_status_pkg.sv */
package link_resolution_status_pkg;

    typedef enum logic [1:0] {
        SPEED_10M,
        SPEED_100M,
        SPEED_1000M,
        SPEED_RSVD
    } link_speed_t;

    // resolved state from the link state machines
    typedef struct packed {
        link_speed_t speed;
        logic fullDuplex;
        logic negotiationSettled;
        logic linkUp;
        logic crossoverPairsCd;
        logic crossoverPairsAb;
        logic gigAbilityMasked;
        logic sleeping;
        logic [3:0] channelPolarityReversed;
        logic polarity10Normal;
        logic overlongTxDetected;
    } link_state_t;

    // management port request
    typedef struct packed {
        logic rdStrobe;
        logic wrStrobe;
        logic [4:0] addr;
        logic [15:0] wrData;
    } mgmt_req_t;

endpackage : link_resolution_status_pkg

/* File: hw/event_latch.sv */
`timescale 1ns/1ps
`include "link_resolution_status_params.svh"

module event_latch
    import link_resolution_status_pkg::*;
#(
    parameter int WIDTH = 16
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // events and clear
    input wire logic [WIDTH-1:0] eventPulse,
    input wire logic [WIDTH-1:0] clearMask,
    // latched flags
    output logic [WIDTH-1:0] flags
);

    logic [WIDTH-1:0] next_flags;

    // set wins over a clear in the same cycle
    assign next_flags = (flags & ~clearMask) | eventPulse;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            flags <= '0;
        end else begin
            flags <= next_flags;
        end
    end

endmodule : event_latch

/* File: hw/link_resolution_status_and_irq_enable_regs.sv */
`timescale 1ns/1ps
`include "link_resolution_status_params.svh"

// Overview of operation
// R1 - bits 15-14 give speed: 00 10M, 01 100M, 10 1000M, 11 reserved
// R2 - bit 13 reads one for full duplex, zero for half
// R3 - bit 12 latches on page received, cleared by reading status
// R4 - bit 11 one when negotiation finished or disabled
// R5 - bit 10 shows link up
// R6 - bit 9 crossover of pairs C/D, bit 8 of pairs A/B
// R7 - bit 7 one while negotiating with gigabit abilities masked
// R8 - bit 6 one while sleeping
// R9 - bits 5-2 polarity reversed for channels D,C,B,A
// R10 - bit 1 one when 10M polarity normal (inverted sense)
// R11 - bit 0 one while jabber present
// R12 - interrupt only raised for events whose enable bit is set
// R13 - sixteen read-write enables, reset zero, bit 15 to bit 0
// R14 - event flags set regardless of enable, cleared on read
// R15 - config bit 13 selects pin polarity: zero high, one low
// R16 - interrupt stays asserted while any enabled flag is pending
module link_resolution_status_and_irq_enable_regs
    import link_resolution_status_pkg::*;
#(
    parameter int NUM_EVENTS = 16
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // management register port
    input wire mgmt_req_t mgmtReq,
    output logic [15:0] mgmtRdData,
    output logic mgmtRdValid,
    // resolved state and events, same clock domain
    input wire link_state_t linkState,
    input wire logic pageReceived,
    input wire logic [NUM_EVENTS-1:0] eventPulse,
    // interrupt pin and pending state
    output logic irqPin,
    output logic irqPending
);

    ////////////////////////////////////////////////////////////////////
    // address decode

    wire rdStatus;
    wire rdEvents;
    wire wrEnables;
    wire wrConfig;
    assign rdStatus = mgmtReq.rdStrobe && mgmtReq.addr == `ADDR_LINK_STATUS;
    assign rdEvents = mgmtReq.rdStrobe && mgmtReq.addr == `ADDR_EVENT_STATUS;
    assign wrEnables = mgmtReq.wrStrobe
        && mgmtReq.addr == `ADDR_EVENT_ENABLE;
    assign wrConfig = mgmtReq.wrStrobe && mgmtReq.addr == `ADDR_GEN_CONFIG;

    ////////////////////////////////////////////////////////////////////
    // writable registers

    logic [15:0] eventEnableRegister;
    logic [15:0] genConfig;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            eventEnableRegister <= `RST_ENABLES; // see R13
            genConfig <= `RST_GEN_CONFIG;
        end else begin
            if (wrEnables) begin
                eventEnableRegister <= mgmtReq.wrData; // see R13
            end
            if (wrConfig) begin
                genConfig <= mgmtReq.wrData;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // latched flags: page flag and event flags share one latch

    logic [NUM_EVENTS:0] latched;
    wire [NUM_EVENTS:0] clearMask;
    wire [NUM_EVENTS-1:0] eventFlags;
    wire pageLatched;

    // a read of each register clears its own latched bits
    assign clearMask = {rdStatus, {NUM_EVENTS{rdEvents}}}; // see R3 see R14

    event_latch #(
        .WIDTH(NUM_EVENTS + 1)
    ) u_latch (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .eventPulse({pageReceived, eventPulse}), // see R14
        .clearMask(clearMask),
        .flags(latched)
    );

    assign pageLatched = latched[NUM_EVENTS]; // see R3
    assign eventFlags = latched[NUM_EVENTS-1:0];

    ////////////////////////////////////////////////////////////////////
    // status word assembly

    wire [15:0] statusWord;
    assign statusWord = {
        linkState.speed,                   // see R1
        linkState.fullDuplex,              // see R2
        pageLatched,                       // see R3
        linkState.negotiationSettled,      // see R4
        linkState.linkUp,                  // see R5
        linkState.crossoverPairsCd,        // see R6
        linkState.crossoverPairsAb,        // see R6
        linkState.gigAbilityMasked,        // see R7
        linkState.sleeping,                // see R8
        linkState.channelPolarityReversed, // see R9
        linkState.polarity10Normal,        // see R10
        linkState.overlongTxDetected       // see R11
    };

    wire [15:0] next_rdData;
    assign next_rdData =
        (mgmtReq.addr == `ADDR_LINK_STATUS) ? statusWord :
        (mgmtReq.addr == `ADDR_EVENT_ENABLE) ? eventEnableRegister :
        (mgmtReq.addr == `ADDR_EVENT_STATUS) ? eventFlags :
        (mgmtReq.addr == `ADDR_GEN_CONFIG) ? genConfig : 16'h0000;

    // read data registered: one cycle after the strobe
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            mgmtRdData <= 16'h0000;
            mgmtRdValid <= 1'b0;
        end else begin
            mgmtRdValid <= mgmtReq.rdStrobe;
            if (mgmtReq.rdStrobe) begin
                mgmtRdData <= next_rdData;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // interrupt output

    wire anyPending;
    // level, not pulse, so a missed edge cannot lose an interrupt
    assign anyPending = |(eventFlags & eventEnableRegister); // see R12 see R16

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            irqPending <= 1'b0;
            irqPin <= 1'b0;
        end else begin
            irqPending <= anyPending; // see R16
            irqPin <= anyPending ^ genConfig[`POS_IRQ_POLARITY]; // see R15
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks

    chk_page_clear_read: assert property ( // see R3
        @(posedge ref_clk) disable iff (!arst_n)
        (rdStatus && !pageReceived) |=> !pageLatched
    ) else $error("page flag not cleared by status read");

    chk_page_hold: assert property ( // see R3
        @(posedge ref_clk) disable iff (!arst_n)
        pageReceived |=> pageLatched
    ) else $error("page flag not latched");

    chk_flag_set_masked: assert property ( // see R14
        @(posedge ref_clk) disable iff (!arst_n)
        (eventPulse & ~eventEnableRegister) != '0
            |=> (eventFlags & $past(eventPulse)) == $past(eventPulse)
    ) else $error("event flag not set while disabled");

    chk_enable_write: assert property ( // see R13
        @(posedge ref_clk) disable iff (!arst_n)
        wrEnables |=> eventEnableRegister == $past(mgmtReq.wrData)
    ) else $error("enable register write lost");

    chk_irq_gating: assert property ( // see R12
        @(posedge ref_clk) disable iff (!arst_n)
        (eventEnableRegister == 16'h0000) |=> !irqPending
    ) else $error("interrupt raised with no enables");

    chk_irq_level: assert property ( // see R16
        @(posedge ref_clk) disable iff (!arst_n)
        |(eventFlags & eventEnableRegister) |=> irqPending
    ) else $error("interrupt not asserted for pending event");

    chk_irq_polarity: assert property ( // see R15
        @(posedge ref_clk) disable iff (!arst_n)
        ##1 irqPin == (irqPending ^ $past(genConfig[13]))
    ) else $error("interrupt pin polarity wrong");

    chk_status_speed: assert property ( // see R1
        @(posedge ref_clk) disable iff (!arst_n)
        rdStatus |=> mgmtRdData[15:14] == $past(linkState.speed)
    ) else $error("speed field wrong");

    chk_status_bits: assert property ( // see R2
        @(posedge ref_clk) disable iff (!arst_n)
        rdStatus |=> mgmtRdData[13] == $past(linkState.fullDuplex)
            && mgmtRdData[1] == $past(linkState.polarity10Normal)
            && mgmtRdData[0] == $past(linkState.overlongTxDetected)
    ) else $error("status bits wrong");

    chk_status_settled: assert property ( // see R4
        @(posedge ref_clk) disable iff (!arst_n)
        rdStatus |=> mgmtRdData[`POS_SETTLED]
            == $past(linkState.negotiationSettled)
    ) else $error("settled bit wrong");

    chk_status_link: assert property ( // see R5
        @(posedge ref_clk) disable iff (!arst_n)
        rdStatus |=> mgmtRdData[`POS_LINK] == $past(linkState.linkUp)
    ) else $error("link bit wrong");

    chk_status_xover: assert property ( // see R6
        @(posedge ref_clk) disable iff (!arst_n)
        rdStatus |=>
            mgmtRdData[`POS_XOVER_CD] == $past(linkState.crossoverPairsCd)
            && mgmtRdData[`POS_XOVER_AB] == $past(linkState.crossoverPairsAb)
    ) else $error("crossover bits wrong");

    chk_status_gig_mask: assert property ( // see R7
        @(posedge ref_clk) disable iff (!arst_n)
        rdStatus |=> mgmtRdData[`POS_GIG_MASKED]
            == $past(linkState.gigAbilityMasked)
    ) else $error("gigabit mask bit wrong");

    chk_status_sleep: assert property ( // see R8
        @(posedge ref_clk) disable iff (!arst_n)
        rdStatus |=> mgmtRdData[`POS_SLEEP] == $past(linkState.sleeping)
    ) else $error("sleep bit wrong");

    chk_status_polarity: assert property ( // see R9
        @(posedge ref_clk) disable iff (!arst_n)
        rdStatus |=> mgmtRdData[`POS_POL_HI:`POS_POL_LO]
            == $past(linkState.channelPolarityReversed)
    ) else $error("channel polarity bits wrong");

    chk_page_sticky: assert property ( // see R3
        @(posedge ref_clk) disable iff (!arst_n)
        pageLatched && !rdStatus |=> pageLatched
    ) else $error("page flag dropped without a read");

    chk_page_quiet: assert property ( // see R3
        @(posedge ref_clk) disable iff (!arst_n)
        !pageLatched && !pageReceived |=> !pageLatched
    ) else $error("page flag set without a page");

    chk_page_event_read: assert property ( // see R3
        @(posedge ref_clk) disable iff (!arst_n)
        rdEvents && !pageReceived |=> pageLatched == $past(pageLatched)
    ) else $error("event read touched page flag");

    chk_event_sticky: assert property ( // see R14
        @(posedge ref_clk) disable iff (!arst_n)
        !rdEvents |=> (eventFlags & $past(eventFlags)) == $past(eventFlags)
    ) else $error("event flag dropped without a read");

    chk_event_read_clear: assert property ( // see R14
        @(posedge ref_clk) disable iff (!arst_n)
        rdEvents |=> eventFlags == $past(eventPulse)
    ) else $error("event read did not clear flags");

    chk_event_quiet: assert property ( // see R14
        @(posedge ref_clk) disable iff (!arst_n)
        eventPulse == '0 |=> (eventFlags & ~$past(eventFlags)) == '0
    ) else $error("event flag set without an event");

    chk_event_status_read: assert property ( // see R14
        @(posedge ref_clk) disable iff (!arst_n)
        rdStatus && eventPulse == '0 |=> eventFlags == $past(eventFlags)
    ) else $error("status read touched event flags");

    chk_enable_hold: assert property ( // see R13
        @(posedge ref_clk) disable iff (!arst_n)
        !wrEnables |=> $stable(eventEnableRegister)
    ) else $error("enable register changed without a write");

    chk_enable_read: assert property ( // see R13
        @(posedge ref_clk) disable iff (!arst_n)
        mgmtReq.rdStrobe && mgmtReq.addr == `ADDR_EVENT_ENABLE
            |=> mgmtRdData == $past(eventEnableRegister)
    ) else $error("enable register read wrong");

    chk_irq_clear: assert property ( // see R16
        @(posedge ref_clk) disable iff (!arst_n)
        (eventFlags & eventEnableRegister) == '0 |=> !irqPending
    ) else $error("interrupt held with nothing pending");

    chk_irq_masked_event: assert property ( // see R12
        @(posedge ref_clk) disable iff (!arst_n)
        (eventPulse & eventEnableRegister) == '0 && !wrEnables
            && (eventFlags & eventEnableRegister) == '0 |=> ##1 !irqPending
    ) else $error("interrupt raised by a disabled event");

    chk_irq_enabled_event: assert property ( // see R12
        @(posedge ref_clk) disable iff (!arst_n)
        (eventPulse & eventEnableRegister) != '0 && !wrEnables
            |=> ##1 irqPending
    ) else $error("enabled event raised no interrupt");

    chk_valid_after_read: assert property ( // see R1
        @(posedge ref_clk) disable iff (!arst_n)
        mgmtReq.rdStrobe |=> mgmtRdValid
    ) else $error("read answer missing");

    chk_rd_data_hold: assert property ( // see R1
        @(posedge ref_clk) disable iff (!arst_n)
        !mgmtReq.rdStrobe |=> $stable(mgmtRdData)
    ) else $error("read data changed without a read");

    chk_pin_follows: assert property ( // see R15
        @(posedge ref_clk) disable iff (!arst_n)
        $stable(genConfig) |->
            irqPin == (irqPending ^ genConfig[`POS_IRQ_POLARITY])
    ) else $error("interrupt pin disagrees with pending and polarity");

    chk_config_write: assert property ( // see R15
        @(posedge ref_clk) disable iff (!arst_n)
        wrConfig |=> genConfig == $past(mgmtReq.wrData)
    ) else $error("configuration write lost");

endmodule : link_resolution_status_and_irq_enable_regs

/* File: bench/link_resolution_status_and_irq_enable_regs_test.sv */
`timescale 1ns/1ps
`include "link_resolution_status_params.svh"

module link_resolution_status_and_irq_enable_regs_test
    import link_resolution_status_pkg::*;
;

logic ref_clk = 1'b0;
logic arst_n = 1'b0;
mgmt_req_t mgmtReq = '0;
link_state_t linkState = '0;
logic pageReceived = 1'b0;
logic [15:0] eventPulse = 16'h0000;
logic [15:0] mgmtRdData;
logic mgmtRdValid;
logic irqPin;
logic irqPending;
int mismatches = 0;
int total_checks = 0;
int cycles = 0;

link_resolution_status_and_irq_enable_regs link_resolution_status_and_irq_enable_regs_i (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .mgmtReq(mgmtReq),
    .mgmtRdData(mgmtRdData),
    .mgmtRdValid(mgmtRdValid),
    .linkState(linkState),
    .pageReceived(pageReceived),
    .eventPulse(eventPulse),
    .irqPin(irqPin),
    .irqPending(irqPending)
);

////////////////////////////////////////////////////////////////////////////
initial forever #2 ref_clk = ~ref_clk;

// whole run is under a hundred cycles, so this only trips on a hang
always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
        mismatches++;
        summarize();
    end
end

task summarize();
    if (mismatches == 0 && total_checks > 0) begin
        $display("Simulation passed");
    end else begin
        $display("Simulation failed");
    end
    $finish;
endtask : summarize

task chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
        mismatches++;
        $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
endtask : chk

////////////////////////////////////////////////////////////////////////////
// answer lands one edge after the strobe edge
task rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    mgmtReq.rdStrobe <= 1'b1;
    mgmtReq.addr <= a;
    @(posedge ref_clk);
    mgmtReq.rdStrobe <= 1'b0;
    #1;
    chk(16'(mgmtRdValid), 16'h0001);
    chk(mgmtRdData, exp);
endtask : rd

task wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    mgmtReq.wrStrobe <= 1'b1;
    mgmtReq.addr <= a;
    mgmtReq.wrData <= d;
    @(posedge ref_clk);
    mgmtReq.wrStrobe <= 1'b0;
endtask : wr

task pulse(input int idx);
    @(posedge ref_clk);
    eventPulse <= 16'h0001 << idx;
    @(posedge ref_clk);
    eventPulse <= 16'h0000;
endtask : pulse

////////////////////////////////////////////////////////////////////////////
initial begin
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(`ADDR_EVENT_ENABLE, 16'h0000);
    wr(`ADDR_EVENT_ENABLE, 16'ha5c3);
    rd(`ADDR_EVENT_ENABLE, 16'ha5c3);
    wr(`ADDR_EVENT_ENABLE, 16'h0001);
    // two patterns that flip every status bit except the page flag
    @(posedge ref_clk);
    linkState <= link_state_t'(15'h56a5);
    rd(`ADDR_LINK_STATUS, 16'ha6a5);
    @(posedge ref_clk);
    linkState <= link_state_t'(15'h295a);
    rd(`ADDR_LINK_STATUS, 16'h495a);
    @(posedge ref_clk);
    pageReceived <= 1'b1;
    @(posedge ref_clk);
    pageReceived <= 1'b0;
    rd(`ADDR_LINK_STATUS, 16'h595a);
    rd(`ADDR_LINK_STATUS, 16'h495a);
    // disabled event still latches, but raises nothing
    pulse(1);
    repeat (2) @(posedge ref_clk);
    #1;
    chk(16'(irqPending), 16'h0000);
    rd(`ADDR_EVENT_STATUS, 16'h0002);
    rd(`ADDR_EVENT_STATUS, 16'h0000);
    pulse(0);
    @(posedge ref_clk);
    #1;
    chk(16'(irqPending), 16'h0001);
    chk(16'(irqPin), 16'h0001);
    rd(`ADDR_EVENT_STATUS, 16'h0001);
    repeat (2) @(posedge ref_clk);
    #1;
    chk(16'(irqPending), 16'h0000);
    // active-low pin idles high
    wr(`ADDR_GEN_CONFIG, 16'h2000);
    repeat (2) @(posedge ref_clk);
    #1;
    chk(16'(irqPin), 16'h0001);
    pulse(0);
    @(posedge ref_clk);
    #1;
    chk(16'(irqPin), 16'h0000);
    rd(`ADDR_EVENT_STATUS, 16'h0001);
    rd(`ADDR_GEN_CONFIG, 16'h2000);
    // status registers are read-only, a write must leave them alone
    wr(`ADDR_EVENT_STATUS, 16'hffff);
    rd(`ADDR_EVENT_STATUS, 16'h0000);
    rd(5'h00, 16'h0000);
    // mid-run reset drops enables, polarity and pending flags
    pulse(3);
    @(posedge ref_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(`ADDR_EVENT_ENABLE, 16'h0000);
    rd(`ADDR_EVENT_STATUS, 16'h0000);
    rd(`ADDR_GEN_CONFIG, 16'h0000);
    chk(16'(irqPin), 16'h0000);
    summarize();
end

endmodule : link_resolution_status_and_irq_enable_regs_test
